// ### hw/rotate_subtract_xor_exec.sv
// decode and execute slice: rotates, bit set, short jump, subtract, swaps, break, xor
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module rotate_subtract_xor_exec #(
  parameter int PC_W = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // instruction and operands
  input wire rsx_pkg::instr_type instr,
  input wire logic instr_valid,
  input wire rsx_pkg::operand_type operands,
  output logic ready_r,
  // results toward data memory and debug
  output rsx_pkg::writeback_type wb_r,
  output logic bit_set_r,
  output logic [7:0] bit_addr_r,
  output logic code_store_r,
  output logic [7:0] code_store_data_r,
  output logic debug_enter_r,
  output logic [PC_W-1:0] pc_out_r,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_r
);

  typedef enum logic {ST_IDLE, ST_BUSY} state_type;

  state_type state_r;
  logic [2:0] cnt_r;
  logic [7:0] acc_r;
  logic cy_r, ac_r, ov_r, par_r;
  logic break_en_r, debug_mode_r;
  logic [PC_W-1:0] pc_r;

  logic go;
  logic [7:0] op;
  logic [7:0] acc_nxt;
  logic cy_nxt, ac_nxt, ov_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic [2:0] cnt_nxt;
  logic [1:0] len;
  rsx_pkg::writeback_type wb_nxt;
  logic bit_set_nxt, code_store_nxt, debug_nxt;
  logic [7:0] src, dir_src;
  logic [8:0] diff9;
  logic [4:0] diff_lo;
  logic [7:0] diff_b7;
  logic is_subtract_with_borrow, is_xch, is_xrl_acc;

  assign go = ce && instr_valid && ready_r;
  assign op = instr.opcode;

  // xor latch source
  // port latch read
  assign dir_src = operands.direct_is_port ? operands.latch_val : operands.direct_val;

  assign is_subtract_with_borrow = ((op & rsx_pkg::MASK_REG) == rsx_pkg::OP_SUBTRACT_WITH_BORROW_REG)
    || ((op & rsx_pkg::MASK_IND) == rsx_pkg::OP_SUBTRACT_WITH_BORROW_IND)
    || op == rsx_pkg::OP_SUBTRACT_WITH_BORROW_DIR || op == rsx_pkg::OP_SUBTRACT_WITH_BORROW_IMM;
  assign is_xch = ((op & rsx_pkg::MASK_REG) == rsx_pkg::OP_XCH_REG)
    || ((op & rsx_pkg::MASK_IND) == rsx_pkg::OP_XCH_IND) || op == rsx_pkg::OP_XCH_DIR;
  assign is_xrl_acc = ((op & rsx_pkg::MASK_REG) == rsx_pkg::OP_XRL_REG)
    || ((op & rsx_pkg::MASK_IND) == rsx_pkg::OP_XRL_IND)
    || op == rsx_pkg::OP_XRL_DIR || op == rsx_pkg::OP_XRL_IMM;

  // operand select by addressing form
  // register, immediate, direct and indirect forms
  always_comb begin
    if ((op & rsx_pkg::MASK_REG) == rsx_pkg::OP_SUBTRACT_WITH_BORROW_REG
        || (op & rsx_pkg::MASK_REG) == rsx_pkg::OP_XCH_REG
        || (op & rsx_pkg::MASK_REG) == rsx_pkg::OP_XRL_REG) begin
      src = operands.reg_val;
    end else if (op == rsx_pkg::OP_SUBTRACT_WITH_BORROW_IMM || op == rsx_pkg::OP_XRL_IMM) begin
      src = instr.byte2;
    end else if (op == rsx_pkg::OP_SUBTRACT_WITH_BORROW_DIR || op == rsx_pkg::OP_XCH_DIR) begin
      src = operands.direct_val;
    end else if (op == rsx_pkg::OP_XRL_DIR) begin
      src = dir_src;
    end else begin
      src = operands.ind_val;
    end
  end

  // borrow chain: full, low nibble, low seven bits
  // acc minus carry minus source
  assign diff9 = {1'b0, acc_r} - {1'b0, src} - {8'h00, cy_r};
  assign diff_lo = {1'b0, acc_r[3:0]} - {1'b0, src[3:0]} - {4'h0, cy_r};
  assign diff_b7 = {1'b0, acc_r[6:0]} - {1'b0, src[6:0]} - {7'h00, cy_r};

  always_comb begin
    acc_nxt = acc_r;
    cy_nxt = cy_r;
    ac_nxt = ac_r;
    ov_nxt = ov_r;
    len = 2'd1;
    cnt_nxt = rsx_pkg::CNT_ONE_MC;
    wb_nxt = '{valid: 1'b0, kind: rsx_pkg::WB_REG, addr: 8'h00, data: 8'h00};
    bit_set_nxt = 1'b0;
    code_store_nxt = 1'b0;
    debug_nxt = 1'b0;
    pc_nxt = pc_r;
    if (op == rsx_pkg::OP_RLC) begin
      acc_nxt = {acc_r[6:0], cy_r};
      cy_nxt = acc_r[7];
    end else if (op == rsx_pkg::OP_RR) begin
      acc_nxt = {acc_r[0], acc_r[7:1]};
    end else if (op == rsx_pkg::OP_RRC) begin
      acc_nxt = {cy_r, acc_r[7:1]};
      cy_nxt = acc_r[0];
    end else if (op == rsx_pkg::OP_SET_BIT_OP_C) begin
      cy_nxt = 1'b1;
    end else if (op == rsx_pkg::OP_SET_BIT_OP_BIT) begin
      bit_set_nxt = 1'b1;
      len = 2'd2;
    end else if (op == rsx_pkg::OP_SHORT_RELATIVE_JUMP) begin
      len = 2'd2;
      cnt_nxt = rsx_pkg::CNT_TWO_MC;
    end else if (is_subtract_with_borrow) begin
      acc_nxt = diff9[7:0];
      cy_nxt = diff9[8];
      ac_nxt = diff_lo[4];
      ov_nxt = diff9[8] ^ diff_b7[7];
      if (op == rsx_pkg::OP_SUBTRACT_WITH_BORROW_DIR || op == rsx_pkg::OP_SUBTRACT_WITH_BORROW_IMM) begin
        len = 2'd2;
      end
    end else if (op == rsx_pkg::OP_SWAP) begin
      acc_nxt = {acc_r[3:0], acc_r[7:4]};
    end else if (op == rsx_pkg::OP_BREAK) begin
      debug_nxt = break_en_r;
      code_store_nxt = !break_en_r;
    end else if (is_xch) begin
      acc_nxt = src;
      wb_nxt.valid = 1'b1;
      wb_nxt.data = acc_r;
      if (op == rsx_pkg::OP_XCH_DIR) begin
        wb_nxt.kind = rsx_pkg::WB_DIRECT;
        wb_nxt.addr = instr.byte2;
        len = 2'd2;
      end else if ((op & rsx_pkg::MASK_REG) == rsx_pkg::OP_XCH_REG) begin
        wb_nxt.addr = {5'h00, op[2:0]};
      end else begin
        wb_nxt.kind = rsx_pkg::WB_INDIRECT;
        wb_nxt.addr = {7'h00, op[0]};
      end
    end else if ((op & rsx_pkg::MASK_IND) == rsx_pkg::OP_EXCHANGE_LOW_DIGIT_IND) begin
      acc_nxt = {acc_r[7:4], operands.ind_val[3:0]};
      wb_nxt = '{valid: 1'b1, kind: rsx_pkg::WB_INDIRECT, addr: {7'h00, op[0]},
                 data: {operands.ind_val[7:4], acc_r[3:0]}};
    end else if (is_xrl_acc) begin
      acc_nxt = acc_r ^ src;
      if (op == rsx_pkg::OP_XRL_DIR || op == rsx_pkg::OP_XRL_IMM) begin
        len = 2'd2;
      end
    end else if (op == rsx_pkg::OP_XRL_DIR_A || op == rsx_pkg::OP_XRL_DIR_IMM) begin
      wb_nxt.valid = 1'b1;
      wb_nxt.kind = rsx_pkg::WB_DIRECT;
      wb_nxt.addr = instr.byte2;
      if (op == rsx_pkg::OP_XRL_DIR_IMM) begin
        wb_nxt.data = dir_src ^ instr.byte3;
        len = 2'd3;
        cnt_nxt = rsx_pkg::CNT_TWO_MC;
      end else begin
        wb_nxt.data = dir_src ^ acc_r;
        len = 2'd2;
      end
    end
    pc_nxt = pc_r + PC_W'(len);
    if (op == rsx_pkg::OP_SHORT_RELATIVE_JUMP) begin
      pc_nxt = pc_r + PC_W'(len) + PC_W'($signed(instr.byte2));
    end
  end

  // occupancy: two clocks per machine cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      ready_r <= 1'b0;
    end else if (ce) begin
      unique case (state_r)
        ST_IDLE: begin
          ready_r <= 1'b1;
          if (go) begin
            state_r <= ST_BUSY;
            cnt_r <= cnt_nxt;
            ready_r <= 1'b0;
          end
        end
        ST_BUSY: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            state_r <= ST_IDLE;
            ready_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // accumulator and flags; execution wins over a same-cycle software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= rsx_pkg::ACC_RST;
      cy_r <= 1'b0;
      ac_r <= 1'b0;
      ov_r <= 1'b0;
      par_r <= 1'b0;
    end else if (ce) begin
      if (go) begin
        acc_r <= acc_nxt;
        cy_r <= cy_nxt;
        ac_r <= ac_nxt;
        ov_r <= ov_nxt;
        par_r <= ^acc_nxt;
      end else if (reg_wr && reg_addr == rsx_pkg::ADDR_ACC) begin
        acc_r <= reg_wdata[7:0];
        par_r <= ^reg_wdata[7:0];
      end else if (reg_wr && reg_addr == rsx_pkg::ADDR_FLAGS) begin
        cy_r <= reg_wdata[rsx_pkg::FLAG_CY];
        ac_r <= reg_wdata[rsx_pkg::FLAG_AC];
        ov_r <= reg_wdata[rsx_pkg::FLAG_OV];
      end
    end
  end

  // program counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_r <= PC_W'(rsx_pkg::PC_RST);
      pc_out_r <= PC_W'(rsx_pkg::PC_RST);
    end else if (ce) begin
      if (go) begin
        pc_r <= pc_nxt;
        pc_out_r <= pc_nxt;
      end else if (reg_wr && reg_addr == rsx_pkg::ADDR_PC) begin
        pc_r <= PC_W'(reg_wdata);
        pc_out_r <= PC_W'(reg_wdata);
      end
    end
  end

  // one-clock result strobes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_r <= '{valid: 1'b0, kind: rsx_pkg::WB_REG, addr: 8'h00, data: 8'h00};
      bit_set_r <= 1'b0;
      bit_addr_r <= 8'h00;
      code_store_r <= 1'b0;
      code_store_data_r <= 8'h00;
      debug_enter_r <= 1'b0;
    end else if (ce) begin
      wb_r <= go ? wb_nxt : rsx_pkg::writeback_type'('0);
      bit_set_r <= go && bit_set_nxt;
      if (go && bit_set_nxt) begin
        bit_addr_r <= instr.byte2;
      end
      code_store_r <= go && code_store_nxt;
      if (go && code_store_nxt) begin
        code_store_data_r <= acc_r;
      end
      // pulse at end of phase one
      debug_enter_r <= go && debug_nxt;
    end
  end

  // control and debug status; a new break beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      break_en_r <= 1'b0;
      debug_mode_r <= 1'b0;
    end else if (ce) begin
      if (reg_wr && reg_addr == rsx_pkg::ADDR_CTRL) begin
        break_en_r <= reg_wdata[rsx_pkg::CTRL_BREAK_EN];
      end
      if (go && debug_nxt) begin
        debug_mode_r <= 1'b1;
      end else if (reg_wr && reg_addr == rsx_pkg::ADDR_STATUS
                   && reg_wdata[rsx_pkg::STAT_DEBUG]) begin
        debug_mode_r <= 1'b0;
      end
    end
  end

  // read port: data the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (ce) begin
      reg_rdata_r <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          rsx_pkg::ADDR_ACC: reg_rdata_r <= {8'h00, acc_r};
          rsx_pkg::ADDR_FLAGS: reg_rdata_r <= {8'h00, cy_r, ac_r, 3'h0, ov_r, 1'b0, par_r};
          rsx_pkg::ADDR_CTRL: reg_rdata_r <= {15'h0000, break_en_r};
          rsx_pkg::ADDR_PC: reg_rdata_r <= 16'(pc_r);
          rsx_pkg::ADDR_STATUS: reg_rdata_r <= {14'h0000, !ready_r, debug_mode_r};
          default: reg_rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  rlc_result_a: assert property (go && op == rsx_pkg::OP_RLC |=>
    acc_r == {$past(acc_r[6:0]), $past(cy_r)} && cy_r == $past(acc_r[7]))
    else $error("rotate left via carry wrong");
  rr_result_a: assert property (go && op == rsx_pkg::OP_RR |=>
    acc_r == {$past(acc_r[0]), $past(acc_r[7:1])} && $stable(cy_r) && $stable(ov_r))
    else $error("plain rotate right wrong");
  rrc_result_a: assert property (go && op == rsx_pkg::OP_RRC |=>
    acc_r == {$past(cy_r), $past(acc_r[7:1])} && cy_r == $past(acc_r[0]) && $stable(ac_r))
    else $error("rotate right via carry wrong");
  set_bit_op_carry_a: assert property (go && op == rsx_pkg::OP_SET_BIT_OP_C |=>
    cy_r && $stable(acc_r) && $stable(ov_r))
    else $error("set carry wrong");
  set_bit_op_bit_a: assert property (go && op == rsx_pkg::OP_SET_BIT_OP_BIT |=>
    bit_set_r && bit_addr_r == $past(instr.byte2) && $stable(cy_r) ##1 !bit_set_r)
    else $error("bit set request wrong");
  short_relative_jump_target_a: assert property (go && op == rsx_pkg::OP_SHORT_RELATIVE_JUMP |=>
    pc_r == $past(pc_r) + PC_W'(2) + PC_W'($signed($past(instr.byte2)))
    ##0 !ready_r [*3] ##1 ready_r)
    else $error("short jump target or duration wrong");
  subtract_with_borrow_carry_a: assert property (go && is_subtract_with_borrow |=>
    cy_r == ({1'b0, $past(acc_r)} < {1'b0, $past(src)} + {8'h00, $past(cy_r)}))
    else $error("subtract borrow wrong");
  subtract_with_borrow_aux_a: assert property (go && is_subtract_with_borrow |=>
    ac_r == ({1'b0, $past(acc_r[3:0])} < {1'b0, $past(src[3:0])} + {4'h0, $past(cy_r)}))
    else $error("subtract auxiliary borrow wrong");
  subtract_with_borrow_value_a: assert property (go && is_subtract_with_borrow |=>
    acc_r == 8'($past(acc_r) - $past(src) - {7'h00, $past(cy_r)}) && !ready_r ##1 ready_r)
    else $error("subtract result wrong");
  break_select_a: assert property (go && op == rsx_pkg::OP_BREAK |=>
    debug_enter_r == $past(break_en_r) && code_store_r == !$past(break_en_r)
    && $stable(cy_r))
    else $error("break opcode selection wrong");
  exchange_low_digit_nibbles_a: assert property (go
    && (op & rsx_pkg::MASK_IND) == rsx_pkg::OP_EXCHANGE_LOW_DIGIT_IND
    |=> acc_r[7:4] == $past(acc_r[7:4]) && wb_r.data[7:4] == $past(operands.ind_val[7:4]))
    else $error("digit exchange wrong");
  xrl_latch_a: assert property (go && op == rsx_pkg::OP_XRL_DIR_A
    && operands.direct_is_port |=> wb_r.data == $past(operands.latch_val ^ acc_r))
    else $error("xor port source wrong");
  parity_track_a: assert property (!$stable(acc_r) |-> par_r == ^acc_r)
    else $error("parity out of step");

  subtract_with_borrow_cover_c: cover property (go && is_subtract_with_borrow && cy_r);
  break_cover_c: cover property (go && op == rsx_pkg::OP_BREAK && break_en_r);
  xrl3_cover_c: cover property (go && op == rsx_pkg::OP_XRL_DIR_IMM);
  short_relative_jump_back_c: cover property (go && op == rsx_pkg::OP_SHORT_RELATIVE_JUMP && instr.byte2[7]);

endmodule // rotate_subtract_xor_exec

// ### pkg/rsx_pkg.sv
// shared constants and carrier types for the rotate/subtract/xor execute slice
package rsx_pkg;

  // timing: two clocks make one machine cycle
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLKS_PER_MC = 2;
  localparam logic [2:0] CNT_ONE_MC = 3'(CLKS_PER_MC - 1);
  localparam logic [2:0] CNT_TWO_MC = 3'(2 * CLKS_PER_MC - 1);

  // opcodes and opcode groups (upper bits compared under mask)
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_RR = 8'h03;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_SET_BIT_OP_C = 8'hd3;
  localparam logic [7:0] OP_SET_BIT_OP_BIT = 8'hd2;
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP = 8'h80;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IMM = 8'h94;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_DIR = 8'h95;
  localparam logic [7:0] OP_SWAP = 8'hc4;
  localparam logic [7:0] OP_BREAK = 8'ha5;
  localparam logic [7:0] OP_XCH_DIR = 8'hc5;
  localparam logic [7:0] OP_XRL_DIR_A = 8'h62;
  localparam logic [7:0] OP_XRL_DIR_IMM = 8'h63;
  localparam logic [7:0] OP_XRL_IMM = 8'h64;
  localparam logic [7:0] OP_XRL_DIR = 8'h65;
  localparam logic [7:0] MASK_REG = 8'hf8;
  localparam logic [7:0] MASK_IND = 8'hfe;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_REG = 8'h98;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IND = 8'h96;
  localparam logic [7:0] OP_XCH_REG = 8'hc8;
  localparam logic [7:0] OP_XCH_IND = 8'hc6;
  localparam logic [7:0] OP_EXCHANGE_LOW_DIGIT_IND = 8'hd6;
  localparam logic [7:0] OP_XRL_REG = 8'h68;
  localparam logic [7:0] OP_XRL_IND = 8'h66;

  // register map, byte addresses
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // flag and control bit positions
  localparam int FLAG_CY = 7;
  localparam int FLAG_AC = 6;
  localparam int FLAG_OV = 2;
  localparam int FLAG_P = 0;
  localparam int CTRL_BREAK_EN = 0;
  localparam int STAT_DEBUG = 0;
  localparam int STAT_BUSY = 1;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;

  // carriers
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } instr_type;

  typedef struct packed {
    logic [7:0] reg_val;
    logic [7:0] ind_val;
    logic [7:0] direct_val;
    logic [7:0] latch_val;
    logic direct_is_port;
  } operand_type;

  typedef enum logic [1:0] {WB_REG, WB_DIRECT, WB_INDIRECT} wb_kind_type;

  typedef struct packed {
    logic valid;
    wb_kind_type kind;
    logic [7:0] addr;
    logic [7:0] data;
  } writeback_type;

endpackage

// ### sim/rotate_subtract_xor_exec_test.sv
// self-checking bench for the rotate/subtract/xor execute slice
`timescale 1ns/100ps
module rotate_subtract_xor_exec_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  rsx_pkg::instr_type instr = '0;
  logic instr_valid = 1'b0;
  rsx_pkg::operand_type operands;
  logic ready_r;
  rsx_pkg::writeback_type wb_r;
  logic bit_set_r;
  logic [7:0] bit_addr_r;
  logic code_store_r;
  logic [7:0] code_store_data_r;
  logic debug_enter_r;
  logic [15:0] pc_out_r;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_r;
  int n_fail = 0;
  int total_checks = 0;
  int stall;
  logic [3:0] seen;
  logic [15:0] v;
  logic [15:0] e;
  // op, acc in, carry in, acc out, carry out
  logic [39:0] rot [5] = '{40'h33_c5_00_8a_01, 40'h33_45_01_8b_00, 40'h03_c5_01_e2_01,
                           40'h13_c5_00_62_01, 40'hc4_c5_01_5c_01};
  logic [23:0] sv [4] = '{24'hc9_01_54, 24'h00_00_01, 24'h80_00_01, 24'h7f_00_ff};
  logic [7:0] sop [4] = '{8'h9a, 8'h95, 8'h97, 8'h94};

  rotate_subtract_xor_exec #(.PC_W(16)) u_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .instr(instr), .instr_valid(instr_valid),
    .operands(operands), .ready_r(ready_r), .wb_r(wb_r), .bit_set_r(bit_set_r),
    .bit_addr_r(bit_addr_r), .code_store_r(code_store_r),
    .code_store_data_r(code_store_data_r), .debug_enter_r(debug_enter_r),
    .pc_out_r(pc_out_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r)
  );
  rsx_data_mem u_mem (.clk(clk), .instr(instr), .wb_r(wb_r), .operands(operands));

  always #50 clk = ~clk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] fl(input logic cy, input logic ac, input logic ov,
                                    input logic [7:0] a);
    return {cy, ac, 3'b000, ov, 1'b0, ^a};
  endfunction
  // borrows worked out bit-slice by bit-slice
  function automatic logic [15:0] sb(input logic [7:0] a, input logic c, input logic [7:0] s);
    logic [8:0] d;
    logic [4:0] l;
    logic [7:0] m;
    d = {1'b0, a} - {1'b0, s} - 9'(c);
    l = {1'b0, a[3:0]} - {1'b0, s[3:0]} - 5'(c);
    m = {1'b0, a[6:0]} - {1'b0, s[6:0]} - 8'(c);
    return {d[7:0], fl(d[8], l[4], d[8] ^ m[7], d[7:0])};
  endfunction
  // strobe dropped one cycle early so back-to-back calls never double-drive
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata_r;
    @(posedge clk);
  endtask
  // ready sampled mid-cycle, where it is settled; pulses caught in cycle one
  task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    instr <= {op, b2, b3};
    instr_valid <= 1'b1;
    stall = 0;
    forever begin
      @(negedge clk);
      if (ready_r === 1'b1 || stall > 20) break;
      stall++;
    end
    // a hung slice counts against the run
    if (ready_r !== 1'b1) begin
      n_fail++;
      $display("unexpected ready: expected 1, seen %b", ready_r);
    end
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    seen = {bit_set_r, code_store_r, debug_enter_r, wb_r.valid};
    @(posedge clk);
  endtask
  task automatic pre(input logic [7:0] a, input logic [7:0] f);
    wr(8'h00, {8'h00, a});
    wr(8'h04, {8'h00, f});
  endtask
  task automatic af(input logic [7:0] a, input logic [7:0] f);
    rd(8'h00);
    check("acc", {8'h00, a}, v);
    rd(8'h04);
    check("flags", {8'h00, f}, v);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h14);
    check("unmapped read", 16'h0000, v);
    // ac and ov held high so any stray flag write shows
    for (int i = 0; i < 5; i++) begin
      pre(rot[i][31:24], fl(rot[i][16], 1'b1, 1'b1, 8'h00));
      run(rot[i][39:32], 8'h00, 8'h00);
      af(rot[i][15:8], fl(rot[i][0], 1'b1, 1'b1, rot[i][15:8]));
    end
    pre(8'h8a, fl(1'b0, 1'b1, 1'b1, 8'h00));
    run(8'hd3, 8'h00, 8'h00);
    af(8'h8a, fl(1'b1, 1'b1, 1'b1, 8'h8a));
    run(8'hd2, 8'h91, 8'h00);
    check("bit set pulse", 16'h0001, {15'h0000, seen[3]});
    check("bit address", 16'h0091, {8'h00, bit_addr_r});
    af(8'h8a, fl(1'b1, 1'b1, 1'b1, 8'h8a));
    // every subtract form against four borrow patterns
    u_mem.wreg[1] = 8'h30;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        u_mem.wreg[2] = sv[i][7:0];
        u_mem.ram[8'h30] = sv[i][7:0];
        pre(sv[i][23:16], fl(sv[i][8], 1'b0, 1'b0, 8'h00));
        run(sop[k], (k == 3) ? sv[i][7:0] : 8'h30, 8'h00);
        e = sb(sv[i][23:16], sv[i][8], sv[i][7:0]);
        af(e[15:8], e[7:0]);
      end
    end
    wr(8'h0c, 16'h0100);
    run(8'h80, 8'h21, 8'h00);
    run(8'h00, 8'h00, 8'h00);
    check("jump stall", 16'h0002, 16'(stall));
    check("pc", 16'h0124, pc_out_r);
    wr(8'h0c, 16'h0100);
    run(8'h80, 8'h80, 8'h00);
    check("pc", 16'h0082, pc_out_r);
    // break only while enabled, otherwise the code store
    wr(8'h08, 16'h0001);
    pre(8'h55, fl(1'b1, 1'b0, 1'b1, 8'h00));
    run(8'ha5, 8'h00, 8'h00);
    check("break pulses", 16'h0001, {13'h0000, seen[3:1]});
    rd(8'h10);
    check("debug status", 16'h0001, v & 16'h0001);
    af(8'h55, fl(1'b1, 1'b0, 1'b1, 8'h55));
    wr(8'h10, 16'h0001);
    rd(8'h10);
    check("debug status", 16'h0000, v & 16'h0001);
    wr(8'h08, 16'h0000);
    run(8'ha5, 8'h00, 8'h00);
    check("store pulses", 16'h0002, {13'h0000, seen[3:1]});
    check("store data", 16'h0055, {8'h00, code_store_data_r});
    u_mem.wreg[0] = 8'h20;
    u_mem.ram[8'h20] = 8'h75;
    pre(8'h3f, 8'hc4);
    run(8'hc6, 8'h00, 8'h00);
    af(8'h75, fl(1'b1, 1'b1, 1'b1, 8'h75));
    check("ram byte", 16'h003f, {8'h00, u_mem.ram[8'h20]});
    run(8'hd6, 8'h00, 8'h00);
    af(8'h7f, fl(1'b1, 1'b1, 1'b1, 8'h7f));
    check("ram byte", 16'h0035, {8'h00, u_mem.ram[8'h20]});
    u_mem.wreg[3] = 8'ha1;
    run(8'hcb, 8'h00, 8'h00);
    // model write lands on the closing edge of run
    @(posedge clk);
    check("working reg", 16'h007f, {8'h00, u_mem.wreg[3]});
    u_mem.ram[8'h30] = 8'h0e;
    run(8'hc5, 8'h30, 8'h00);
    @(posedge clk);
    check("direct byte", 16'h00a1, {8'h00, u_mem.ram[8'h30]});
    af(8'h0e, fl(1'b1, 1'b1, 1'b1, 8'h0e));
    // xor into acc from all four sources
    pre(8'hc3, 8'hc4);
    u_mem.wreg[0] = 8'haa;
    run(8'h68, 8'h00, 8'h00);
    af(8'h69, fl(1'b1, 1'b1, 1'b1, 8'h69));
    run(8'h64, 8'h0f, 8'h00);
    u_mem.ram[8'h30] = 8'hf0;
    run(8'h65, 8'h30, 8'h00);
    run(8'h67, 8'h00, 8'h00);
    af(8'h66, fl(1'b1, 1'b1, 1'b1, 8'h66));
    u_mem.latch[8'h90] = 8'h34;
    run(8'h63, 8'h90, 8'h31);
    run(8'h62, 8'h90, 8'h00);
    check("xor stall", 16'h0002, 16'(stall));
    run(8'h00, 8'h00, 8'h00);
    check("xor stall", 16'h0000, 16'(stall));
    check("port latch", 16'h0063, {8'h00, u_mem.latch[8'h90]});
    // enable low must freeze the accumulator against a write
    ce <= 1'b0;
    wr(8'h00, 16'h0011);
    ce <= 1'b1;
    af(8'h66, fl(1'b1, 1'b1, 1'b1, 8'h66));
    wrap_up();
  end
endmodule // rotate_subtract_xor_exec_test

// ### sim/rsx_data_mem.sv
// behavioural data memory, working registers and port latches beside the slice
`timescale 1ns/100ps
module rsx_data_mem (
  // clock
  input wire logic clk,
  // instruction presented to the core
  input wire rsx_pkg::instr_type instr,
  // writes coming back from the core
  input wire rsx_pkg::writeback_type wb_r,
  output rsx_pkg::operand_type operands
);
  logic [7:0] wreg [8];
  logic [7:0] ram [256];
  logic [7:0] latch [256];
  logic [7:0] ptr;
  logic is_port;
  // ports only on the row bases above 7f
  assign is_port = instr.byte2[7] && (instr.byte2[3:0] == 4'h0);
  assign ptr = wreg[{2'b00, instr.opcode[0]}];
  // pins differ
  // pins read back inverted, so a pin read can never pass for a latch read
  always_comb begin
    operands.reg_val = wreg[instr.opcode[2:0]];
    operands.ind_val = ram[ptr];
    operands.direct_val = is_port ? ~latch[instr.byte2] : ram[instr.byte2];
    operands.latch_val = latch[instr.byte2];
    operands.direct_is_port = is_port;
  end
  always @(posedge clk) begin
    if (wb_r.valid) begin
      case (wb_r.kind)
        rsx_pkg::WB_REG: wreg[wb_r.addr[2:0]] <= wb_r.data;
        rsx_pkg::WB_INDIRECT: ram[wreg[{2'b00, wb_r.addr[0]}]] <= wb_r.data;
        default: begin
          if (wb_r.addr[7] && (wb_r.addr[3:0] == 4'h0)) latch[wb_r.addr] <= wb_r.data;
          else ram[wb_r.addr] <= wb_r.data;
        end
      endcase
    end
  end
endmodule // rsx_data_mem
